/* File: hw/scrp_device.sv */
// module end: serial port, stream/command modes, settings and general-purpose pins
//
// Contract
// - bytes are 8 data, no parity, one stop
// - host sends module-bound bytes on serial input
// - module sends host-bound bytes on serial output
// - local clear-to-send reproduced on peer's request-to-send
// - host asserts clear-to-send only when it can accept
// - baud rate is a configurable setting
// - saved pin assignments apply after power cycle
// - flow control disabled until configured
// - saved escape sequence enters command mode
// - stream command leaves command mode
// - mode pin level selects the mode
// - eight pins: control, indicator or plain I/O
// - local commands run only in command mode
// - key-value settings; saved values define startup
// - command is name followed by arguments
// - remote commands run unless remotely disabled
`timescale 1ns/1ns
module scrp_device (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pwr_cycle,
    // host serial link
    scrp_link_if.dev link,
    // wireless side
    output logic [7:0] air_tx_byte,
    output logic air_tx_valid,
    input wire logic [7:0] air_rx_byte,
    input wire logic air_rx_valid,
    input wire logic air_rx_cmd,
    output logic air_rx_ready,
    output logic air_cts_out,
    input wire logic air_cts_in,
    // general-purpose pins
    input wire logic [7:0] gpio_in,
    output logic [7:0] gpio_out,
    output logic [7:0] gpio_oe_n,
    // status
    output logic cmd_mode
);

    typedef enum logic {
        SCRP_P_NAME = 1'b0,
        SCRP_P_ARG = 1'b1
    } scrp_parse_t;

    typedef struct packed {
        logic ser_s1;
        logic ser_s2;
        logic cts_s1;
        logic cts_s2;
        logic [7:0] gpi_s1;
        logic [7:0] gpi_s2;
        logic rx_busy;
        logic [12:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic tx_busy;
        logic [12:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic tq_valid;
        logic [7:0] tq_byte;
        logic air_rdy;
        logic air_valid;
        logic [7:0] air_byte;
        logic air_cts;
        logic rts_n;
        logic cmd_mode;
        logic flow_en;
        logic [1:0] baud;
        logic [7:0] esc_char;
        logic rdis;
        logic [1:0] esc_cnt;
        logic fl_act;
        logic [1:0] fl_cnt;
        logic [7:0] fl_byte;
        scrp_parse_t pst;
        logic [7:0] pname;
        logic [7:0] out_lvl;
        logic [7:0] dir;
        logic [7:0] ind;
        logic [3:0] mpin;
        logic nv_flow;
        logic [1:0] nv_baud;
        logic [7:0] nv_esc;
        logic nv_rdis;
        logic [7:0] nv_dir;
        logic [7:0] nv_ind;
        logic [3:0] nv_mpin;
        logic [7:0] gpo;
        logic [7:0] gpo_oe_n;
    } scrp_dev_st_t;

    scrp_dev_st_t s_reg;
    scrp_dev_st_t s_next;

    always_comb begin
        logic rx_done;
        logic pvalid;
        logic [7:0] pbyte;
        logic [12:0] div;
        rx_done = 1'b0;
        pvalid = 1'b0;
        pbyte = 8'h00;
        div = scrp_pkg::baud_div(s_reg.baud);
        s_next = s_reg;
        s_next.ser_s1 = link.ser_in;
        s_next.ser_s2 = s_reg.ser_s1;
        s_next.cts_s1 = ~link.cts_n;
        s_next.cts_s2 = s_reg.cts_s1;
        s_next.gpi_s1 = gpio_in;
        s_next.gpi_s2 = s_reg.gpi_s1;
        s_next.air_valid = 1'b0;

        // ********************************
        // receiver, sampled mid-bit
        // ********************************
        if (!s_reg.rx_busy) begin
            if (!s_reg.ser_s2) begin
                s_next.rx_busy = 1'b1;
                s_next.rx_cnt = div >> 1;
                s_next.rx_bit = 4'h0;
            end
        end else if (s_reg.rx_cnt != 13'h0000) begin
            s_next.rx_cnt = s_reg.rx_cnt - 13'h0001;
        end else begin
            s_next.rx_cnt = div - 13'h0001;
            s_next.rx_bit = s_reg.rx_bit + 4'h1;
            if (s_reg.rx_bit == 4'h0) begin
                s_next.rx_busy = ~s_reg.ser_s2;
            end else if (s_reg.rx_bit == scrp_pkg::BIT_STOP) begin
                s_next.rx_busy = 1'b0;
                rx_done = s_reg.ser_s2;
            end else begin
                s_next.rx_sh = {s_reg.ser_s2, s_reg.rx_sh[7:1]};
            end
        end

        // ********************************
        // transmitter toward the host
        // ********************************
        if (s_reg.tx_busy) begin
            if (s_reg.tx_cnt != 13'h0000) begin
                s_next.tx_cnt = s_reg.tx_cnt - 13'h0001;
            end else begin
                s_next.tx_cnt = div - 13'h0001;
                s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
                s_next.tx_bit = s_reg.tx_bit + 4'h1;
                if (s_reg.tx_bit == scrp_pkg::BIT_STOP) begin
                    s_next.tx_busy = 1'b0;
                end
            end
        end else if (s_reg.tq_valid && (!s_reg.flow_en || s_reg.cts_s2)) begin
            s_next.tx_busy = 1'b1;
            s_next.tx_sh = {1'b1, s_reg.tq_byte, 1'b0};
            s_next.tx_cnt = div - 13'h0001;
            s_next.tx_bit = 4'h0;
            s_next.tq_valid = 1'b0;
        end

        // ********************************
        // bytes from the wireless side
        // ********************************
        if (air_rx_valid && s_reg.air_rdy) begin
            if (!air_rx_cmd) begin
                s_next.tq_valid = 1'b1;
                s_next.tq_byte = air_rx_byte;
            end else if (!s_reg.rdis && !(rx_done && s_reg.cmd_mode)) begin
                pvalid = 1'b1;
                pbyte = air_rx_byte;
            end
        end
        if (rx_done && s_reg.cmd_mode) begin
            pvalid = 1'b1;
            pbyte = s_reg.rx_sh;
        end

        // ********************************
        // streaming with escape detection
        // ********************************
        if (s_reg.fl_act) begin
            s_next.air_valid = 1'b1;
            if (s_reg.fl_cnt != 2'h0) begin
                s_next.air_byte = s_reg.esc_char;
                s_next.fl_cnt = s_reg.fl_cnt - 2'h1;
            end else begin
                s_next.air_byte = s_reg.fl_byte;
                s_next.fl_act = 1'b0;
            end
        end else if (rx_done && !s_reg.cmd_mode) begin
            if (s_reg.esc_char != scrp_pkg::ESC_NONE && s_reg.rx_sh == s_reg.esc_char) begin
                s_next.esc_cnt = s_reg.esc_cnt + 2'h1;
                if (s_reg.esc_cnt + 2'h1 == scrp_pkg::ESC_LEN) begin
                    s_next.esc_cnt = 2'h0;
                    s_next.cmd_mode = 1'b1;
                end
            end else if (s_reg.esc_cnt != 2'h0) begin
                // partial sequence broken: replay it before the byte
                s_next.fl_act = 1'b1;
                s_next.fl_cnt = s_reg.esc_cnt;
                s_next.fl_byte = s_reg.rx_sh;
                s_next.esc_cnt = 2'h0;
            end else begin
                s_next.air_valid = 1'b1;
                s_next.air_byte = s_reg.rx_sh;
            end
        end

        // ********************************
        // command parser: name then argument
        // ********************************
        if (pvalid) begin
            if (s_reg.pst == SCRP_P_NAME) begin
                unique case (pbyte)
                    scrp_pkg::CMD_STREAM: s_next.cmd_mode = 1'b0;
                    scrp_pkg::CMD_IN: begin
                        if (!s_next.tq_valid) begin
                            s_next.tq_valid = 1'b1;
                            s_next.tq_byte = s_reg.gpi_s2;
                        end
                    end
                    scrp_pkg::CMD_SAVE: begin
                        s_next.nv_flow = s_reg.flow_en;
                        s_next.nv_baud = s_reg.baud;
                        s_next.nv_esc = s_reg.esc_char;
                        s_next.nv_rdis = s_reg.rdis;
                    end
                    scrp_pkg::CMD_FLOW, scrp_pkg::CMD_BAUD, scrp_pkg::CMD_ESC,
                    scrp_pkg::CMD_RDIS, scrp_pkg::CMD_OUT, scrp_pkg::CMD_DIR,
                    scrp_pkg::CMD_IND, scrp_pkg::CMD_MPIN: begin
                        s_next.pst = SCRP_P_ARG;
                        s_next.pname = pbyte;
                    end
                    default: s_next.pst = SCRP_P_NAME;
                endcase
            end else begin
                s_next.pst = SCRP_P_NAME;
                unique case (s_reg.pname)
                    scrp_pkg::CMD_FLOW: s_next.flow_en = pbyte[0];
                    scrp_pkg::CMD_BAUD: s_next.baud = pbyte[1:0];
                    scrp_pkg::CMD_ESC: s_next.esc_char = pbyte;
                    scrp_pkg::CMD_RDIS: s_next.rdis = pbyte[0];
                    scrp_pkg::CMD_OUT: s_next.out_lvl = pbyte;
                    scrp_pkg::CMD_DIR: s_next.nv_dir = pbyte;
                    scrp_pkg::CMD_IND: s_next.nv_ind = pbyte;
                    scrp_pkg::CMD_MPIN: s_next.nv_mpin = pbyte[3:0];
                    default: s_next.pst = SCRP_P_NAME;
                endcase
            end
        end

        // ********************************
        // power cycle reloads saved settings
        // ********************************
        if (pwr_cycle) begin
            s_next.flow_en = s_reg.nv_flow;
            s_next.baud = s_reg.nv_baud;
            s_next.esc_char = s_reg.nv_esc;
            s_next.rdis = s_reg.nv_rdis;
            s_next.dir = s_reg.nv_dir;
            s_next.ind = s_reg.nv_ind;
            s_next.mpin = s_reg.nv_mpin;
            s_next.cmd_mode = 1'b0;
            s_next.esc_cnt = 2'h0;
            s_next.pst = SCRP_P_NAME;
        end else if (s_reg.mpin[3]) begin
            s_next.cmd_mode = s_reg.gpi_s2[s_reg.mpin[2:0]];
        end

        // ********************************
        // pins and flow-control outputs
        // ********************************
        for (int i = 0; i < 8; i++) begin
            s_next.gpo[i] = s_next.ind[i] ? s_next.cmd_mode : s_next.out_lvl[i];
        end
        s_next.gpo_oe_n = ~(s_next.dir | s_next.ind);
        s_next.air_cts = s_reg.cts_s2;
        s_next.rts_n = ~(air_cts_in || !s_next.flow_en);
        s_next.air_rdy = ~s_next.tq_valid;

        if (sys_rst) begin
            s_next = '0;
            s_next.ser_s1 = 1'b1;
            s_next.ser_s2 = 1'b1;
            s_next.tx_sh = scrp_pkg::LINE_IDLE;
            s_next.baud = scrp_pkg::BAUD_DEFAULT;
            s_next.nv_baud = scrp_pkg::BAUD_DEFAULT;
            s_next.gpo_oe_n = 8'hFF;
            s_next.air_rdy = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_reg <= s_next;
    end

    assign link.ser_out = s_reg.tx_sh[0];
    assign link.rts_n = s_reg.rts_n;
    assign air_tx_byte = s_reg.air_byte;
    assign air_tx_valid = s_reg.air_valid;
    assign air_rx_ready = s_reg.air_rdy;
    assign air_cts_out = s_reg.air_cts;
    assign gpio_out = s_reg.gpo;
    assign gpio_oe_n = s_reg.gpo_oe_n;
    assign cmd_mode = s_reg.cmd_mode;

endmodule

/* File: hw/scrp_pkg.sv */
// constants shared by both ends of the serial cable replacement port
package scrp_pkg;

    // ********************************
    // clock and serial framing
    // ********************************
    localparam int CLK_HZ = 32'h02FA_F080;
    localparam int BAUD_RATE_0 = 32'h0000_2580;
    localparam int BAUD_RATE_1 = 32'h0001_C200;
    localparam int BAUD_RATE_2 = 32'h0000_E100;
    localparam int BAUD_RATE_3 = 32'h0003_8400;
    localparam logic [1:0] BAUD_DEFAULT = 2'h1;
    localparam logic [3:0] BIT_STOP = 4'h9;
    localparam logic [9:0] LINE_IDLE = 10'h3FF;

    // ********************************
    // escape sequence
    // ********************************
    localparam logic [1:0] ESC_LEN = 2'h3;
    localparam logic [7:0] ESC_NONE = 8'h00;

    // ********************************
    // command names
    // ********************************
    localparam logic [7:0] CMD_STREAM = 8'h53;
    localparam logic [7:0] CMD_FLOW = 8'h46;
    localparam logic [7:0] CMD_BAUD = 8'h42;
    localparam logic [7:0] CMD_ESC = 8'h45;
    localparam logic [7:0] CMD_RDIS = 8'h52;
    localparam logic [7:0] CMD_OUT = 8'h4F;
    localparam logic [7:0] CMD_IN = 8'h49;
    localparam logic [7:0] CMD_DIR = 8'h44;
    localparam logic [7:0] CMD_IND = 8'h41;
    localparam logic [7:0] CMD_MPIN = 8'h4D;
    localparam logic [7:0] CMD_SAVE = 8'h57;

    // ********************************
    // clock cycles per bit for a baud index
    // ********************************
    function automatic logic [12:0] baud_div(input logic [1:0] idx);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (idx)
            2'h0: d = CLK_HZ / BAUD_RATE_0;
            2'h1: d = CLK_HZ / BAUD_RATE_1;
            2'h2: d = CLK_HZ / BAUD_RATE_2;
            2'h3: d = CLK_HZ / BAUD_RATE_3;
        endcase
        return d[12:0];
    endfunction

endpackage

/* File: hw/scrp_link_if.sv */
// host serial link between the module end and the host end
`timescale 1ns/1ns
interface scrp_link_if;
    logic ser_in;
    logic ser_out;
    logic cts_n;
    logic rts_n;

    modport dev (
        input ser_in,
        input cts_n,
        output ser_out,
        output rts_n
    );

    modport host (
        output ser_in,
        output cts_n,
        input ser_out,
        input rts_n
    );
endinterface

/* File: hw/scrp_host.sv */
// host end: serial port of the embedded controller facing the module
`timescale 1ns/1ns
module scrp_host (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    // host serial link
    scrp_link_if.host link,
    // setup
    input wire logic [1:0] baud_sel,
    input wire logic use_flow,
    // bytes toward the module
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    // bytes from the module
    output logic [7:0] rx_byte,
    output logic rx_valid,
    input wire logic rx_able
);

    typedef struct packed {
        logic ser_s1;
        logic ser_s2;
        logic rts_s1;
        logic rts_s2;
        logic rx_busy;
        logic [12:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_v;
        logic tx_busy;
        logic [12:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic tx_rdy;
        logic cts_n;
    } scrp_host_st_t;

    scrp_host_st_t s_reg;
    scrp_host_st_t s_next;

    always_comb begin
        logic [12:0] div;
        div = scrp_pkg::baud_div(baud_sel);
        s_next = s_reg;
        s_next.ser_s1 = link.ser_out;
        s_next.ser_s2 = s_reg.ser_s1;
        s_next.rts_s1 = ~link.rts_n;
        s_next.rts_s2 = s_reg.rts_s1;
        s_next.rx_v = 1'b0;

        // ********************************
        // receiver
        // ********************************
        if (!s_reg.rx_busy) begin
            if (!s_reg.ser_s2) begin
                s_next.rx_busy = 1'b1;
                s_next.rx_cnt = div >> 1;
                s_next.rx_bit = 4'h0;
            end
        end else if (s_reg.rx_cnt != 13'h0000) begin
            s_next.rx_cnt = s_reg.rx_cnt - 13'h0001;
        end else begin
            s_next.rx_cnt = div - 13'h0001;
            s_next.rx_bit = s_reg.rx_bit + 4'h1;
            if (s_reg.rx_bit == 4'h0) begin
                s_next.rx_busy = ~s_reg.ser_s2;
            end else if (s_reg.rx_bit == scrp_pkg::BIT_STOP) begin
                s_next.rx_busy = 1'b0;
                s_next.rx_v = s_reg.ser_s2;
            end else begin
                s_next.rx_sh = {s_reg.ser_s2, s_reg.rx_sh[7:1]};
            end
        end

        // ********************************
        // transmitter toward the module
        // ********************************
        if (s_reg.tx_busy) begin
            if (s_reg.tx_cnt != 13'h0000) begin
                s_next.tx_cnt = s_reg.tx_cnt - 13'h0001;
            end else begin
                s_next.tx_cnt = div - 13'h0001;
                s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
                s_next.tx_bit = s_reg.tx_bit + 4'h1;
                s_next.tx_busy = s_reg.tx_bit != scrp_pkg::BIT_STOP;
            end
        end else if (tx_valid && s_reg.tx_rdy) begin
            s_next.tx_busy = 1'b1;
            s_next.tx_sh = {1'b1, tx_byte, 1'b0};
            s_next.tx_cnt = div - 13'h0001;
            s_next.tx_bit = 4'h0;
        end
        s_next.tx_rdy = !s_next.tx_busy && (!use_flow || s_reg.rts_s2);
        s_next.cts_n = ~rx_able;

        if (sys_rst) begin
            s_next = '0;
            s_next.ser_s1 = 1'b1;
            s_next.ser_s2 = 1'b1;
            s_next.tx_sh = scrp_pkg::LINE_IDLE;
            s_next.cts_n = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_reg <= s_next;
    end

    assign link.ser_in = s_reg.tx_sh[0];
    assign link.cts_n = s_reg.cts_n;
    assign tx_ready = s_reg.tx_rdy;
    assign rx_byte = s_reg.rx_sh;
    assign rx_valid = s_reg.rx_v;

endmodule

/* File: sim/scrp_link_props.sv */
// assertions on the host serial link between the two ends
`timescale 1ns/1ns
module scrp_link_props (
    // system
    input wire logic clk_sys,
    input wire logic sys_rst,
    // host serial link
    input wire logic ser_in,
    input wire logic ser_out,
    input wire logic cts_n,
    input wire logic rts_n
);
    // ********************************
    // run-length counters per line level
    // ********************************
    localparam logic [15:0] MIN_BIT = 16'h00D9;
    localparam logic [15:0] MAX_LOW = 16'hB718;
    logic [15:0] out_lo_reg;
    logic [15:0] out_hi_reg;
    logic [15:0] in_lo_reg;
    logic [15:0] in_hi_reg;

    function automatic logic [15:0] sat(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    // high counters start at MIN_BIT so an early frame counts as after idle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_lo_reg <= 16'h0000;
            out_hi_reg <= MIN_BIT;
            in_lo_reg <= 16'h0000;
            in_hi_reg <= MIN_BIT;
        end else begin
            out_lo_reg <= ser_out ? 16'h0000 : sat(out_lo_reg);
            out_hi_reg <= ser_out ? sat(out_hi_reg) : 16'h0000;
            in_lo_reg <= ser_in ? 16'h0000 : sat(in_lo_reg);
            in_hi_reg <= ser_in ? sat(in_hi_reg) : 16'h0000;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // ********************************
    // assertions
    // ********************************
    AST_IDLE_AFTER_RST: assert property ($fell(sys_rst) |-> ser_out && ser_in)
        else $error("serial lines not idle after reset");
    AST_CTS_AFTER_RST: assert property ($fell(sys_rst) |-> cts_n)
        else $error("host ready before reset ended");
    AST_RTS_AFTER_RST: assert property ($fell(sys_rst) |-> !rts_n)
        else $error("flow control active after reset");
    AST_OUT_START_HOLD: assert property ($fell(ser_out) |-> !ser_out [*8])
        else $error("start bit on module output too short");
    AST_OUT_BIT_LOW: assert property ($rose(ser_out) |-> out_lo_reg >= MIN_BIT)
        else $error("low run on module output shorter than a bit");
    AST_OUT_BIT_HIGH: assert property ($fell(ser_out) |-> out_hi_reg >= MIN_BIT)
        else $error("high run on module output shorter than a bit");
    AST_IN_BIT_LOW: assert property ($rose(ser_in) |-> in_lo_reg >= MIN_BIT)
        else $error("low run on module input shorter than a bit");
    AST_IN_BIT_HIGH: assert property ($fell(ser_in) |-> in_hi_reg >= MIN_BIT)
        else $error("high run on module input shorter than a bit");
    AST_OUT_STOP_DUE: assert property (!ser_out |-> out_lo_reg < MAX_LOW)
        else $error("module output low beyond nine bits");
    AST_IN_STOP_DUE: assert property (!ser_in |-> in_lo_reg < MAX_LOW)
        else $error("module input low beyond nine bits");

    cover property ($fell(ser_in));
    cover property ($fell(ser_out));
    cover property ($rose(rts_n));
endmodule

/* File: sim/serial_cable_replacement_port_tb.sv */
// self-checking bench joining the module end and the host end
`timescale 1ns/1ns
module serial_cable_replacement_port_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic pwr_cycle = 1'b0;
    logic [7:0] air_rx_byte = 8'h00;
    logic air_rx_valid = 1'b0;
    logic air_rx_cmd = 1'b0;
    logic air_cts_in = 1'b1;
    logic [7:0] gpio_in = 8'h00;
    logic [1:0] baud_sel = 2'h1;
    logic use_flow = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic tx_valid = 1'b0;
    logic rx_able = 1'b1;
    logic [7:0] air_tx_byte, rx_byte, gpio_out, gpio_oe_n;
    logic air_tx_valid, air_rx_ready, air_cts_out, cmd_mode, tx_ready, rx_valid;
    logic [15:0] lfsr_reg = 16'hFDA7;
    logic [7:0] air_q[$];
    logic [7:0] host_q[$];
    int num_errors = 0;
    int cmp_count = 0;

    scrp_link_if link();
    scrp_device u_scrp_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .pwr_cycle(pwr_cycle),
        .link(link), .air_tx_byte(air_tx_byte), .air_tx_valid(air_tx_valid),
        .air_rx_byte(air_rx_byte), .air_rx_valid(air_rx_valid), .air_rx_cmd(air_rx_cmd),
        .air_rx_ready(air_rx_ready), .air_cts_out(air_cts_out), .air_cts_in(air_cts_in),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .cmd_mode(cmd_mode));
    scrp_host u_scrp_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
        .baud_sel(baud_sel), .use_flow(use_flow), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_able(rx_able));
    scrp_link_props u_scrp_link_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .ser_in(link.ser_in), .ser_out(link.ser_out), .cts_n(link.cts_n), .rts_n(link.rts_n));

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    // collect bytes leaving toward the air and toward the host user
    always @(posedge clk_sys) begin
        if (air_tx_valid === 1'b1) air_q.push_back(air_tx_byte);
        if (rx_valid === 1'b1) host_q.push_back(rx_byte);
    end

    // ********************************
    // helpers
    // ********************************
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic int bit_cycles(input logic [1:0] idx);
        case (idx)
            2'h0: return 5208;
            2'h1: return 434;
            2'h2: return 868;
            default: return 217;
        endcase
    endfunction

    // empty queue yields unknown so the compare fails
    function automatic logic [7:0] pop(input logic from_host);
        if (from_host) return (host_q.size() == 0) ? 8'hxx : host_q.pop_front();
        return (air_q.size() == 0) ? 8'hxx : air_q.pop_front();
    endfunction

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // hold the byte until taken, then let the frame cross the wire
    task automatic host_send(input logic [7:0] b);
        int n;
        n = 0;
        @(posedge clk_sys);
        tx_byte <= b;
        tx_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (tx_ready !== 1'b1 && n < 3000);
        tx_valid <= 1'b0;
        if (tx_ready !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: host send never taken", $time);
        end
        cycles(11 * bit_cycles(baud_sel));
    endtask

    task automatic air_send(input logic [7:0] b, input logic is_cmd);
        int n;
        n = 0;
        @(posedge clk_sys);
        air_rx_byte <= b;
        air_rx_cmd <= is_cmd;
        air_rx_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (air_rx_ready !== 1'b1 && n < 3000);
        air_rx_valid <= 1'b0;
        if (air_rx_ready !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: air send never taken", $time);
        end
        cycles(2);
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        cycles(90000);
        num_errors++;
        tally_and_finish();
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        int i;
        logic [7:0] b;
        cycles(10);
        sys_rst <= 1'b0;
        cycles(3);
        chk_bit(cmd_mode, 1'b0);
        chk_byte(gpio_oe_n, 8'hFF);
        chk_bit(link.rts_n, 1'b0);
        air_send(scrp_pkg::CMD_ESC, 1'b1);
        air_send(8'h2B, 1'b1);
        air_send(scrp_pkg::CMD_BAUD, 1'b1);
        air_send(8'h03, 1'b1);
        baud_sel <= 2'h3;
        for (i = 0; i < 10; i++) begin
            lfsr_reg = lfsr_step(lfsr_reg);
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lfsr_reg[7:0];
            if (b == 8'h2B) b = 8'h2C;
            host_send(b);
            chk_byte(pop(1'b0), b);
        end
        host_send(8'h2B);
        host_send(8'h61);
        chk_byte(pop(1'b0), 8'h2B);
        chk_byte(pop(1'b0), 8'h61);
        chk_bit(cmd_mode, 1'b0);
        repeat (3) host_send(8'h2B);
        chk_bit(cmd_mode, 1'b1);
        chk_byte(8'(air_q.size()), 8'h00);
        host_send(scrp_pkg::CMD_OUT);
        host_send(8'hA5);
        chk_byte(gpio_out, 8'hA5);
        b = lfsr_reg[15:8];
        gpio_in <= b;
        host_send(scrp_pkg::CMD_IN);
        cycles(11 * 217);
        chk_byte(pop(1'b1), b);
        host_send(scrp_pkg::CMD_FLOW);
        host_send(8'h01);
        use_flow <= 1'b1;
        air_cts_in <= 1'b0;
        cycles(4);
        chk_bit(link.rts_n, 1'b1);
        air_cts_in <= 1'b1;
        cycles(4);
        chk_bit(link.rts_n, 1'b0);
        rx_able <= 1'b0;
        cycles(6);
        chk_bit(air_cts_out, 1'b0);
        host_send(scrp_pkg::CMD_DIR);
        host_send(8'h0F);
        host_send(scrp_pkg::CMD_MPIN);
        host_send(8'h0E);
        host_send(scrp_pkg::CMD_IND);
        host_send(8'h80);
        host_send(scrp_pkg::CMD_SAVE);
        chk_byte(gpio_oe_n, 8'hFF);
        host_send(scrp_pkg::CMD_STREAM);
        chk_bit(cmd_mode, 1'b0);
        host_send(scrp_pkg::CMD_OUT);
        chk_byte(pop(1'b0), scrp_pkg::CMD_OUT);
        air_send(8'h5A, 1'b0);
        cycles(11 * 217);
        chk_byte(8'(host_q.size()), 8'h00);
        rx_able <= 1'b1;
        cycles(6 + 11 * 217);
        chk_bit(air_cts_out, 1'b1);
        chk_byte(pop(1'b1), 8'h5A);
        air_send(scrp_pkg::CMD_RDIS, 1'b1);
        air_send(8'h01, 1'b1);
        air_send(scrp_pkg::CMD_OUT, 1'b1);
        air_send(8'h3C, 1'b1);
        chk_byte(gpio_out, 8'hA5);
        gpio_in <= 8'h40;
        pwr_cycle <= 1'b1;
        @(posedge clk_sys);
        pwr_cycle <= 1'b0;
        cycles(6);
        chk_byte(gpio_oe_n, 8'h70);
        chk_bit(cmd_mode, 1'b1);
        chk_byte(gpio_out, 8'hA5);
        gpio_in <= 8'h00;
        cycles(6);
        chk_bit(cmd_mode, 1'b0);
        chk_byte(gpio_out, 8'h25);
        // saved flow control is live again after the power cycle
        air_cts_in <= 1'b0;
        cycles(4);
        chk_bit(link.rts_n, 1'b1);
        tally_and_finish();
    end
endmodule
